/* rail_status_pkg.sv */
// shared offsets, bit positions and reset values of the rail status bank
package rail_status_pkg;
  localparam int          ADDR_W                = 8;
  localparam int          DATA_W                = 8;
  localparam int          SYNC_STAGES           = 2;
  localparam logic [7:0]  RAIL_GOOD_B_OFFSET    = 8'hb1;
  localparam logic [7:0]  POWER_FAULT_A_OFFSET  = 8'hb2;
  localparam logic [7:0]  POWER_FAULT_B_OFFSET  = 8'hb3;
  localparam logic [7:0]  THERMAL_CRIT_OFFSET   = 8'hb4;
  localparam logic [7:0]  FLAG_RESET            = 8'h00;
  localparam logic [7:0]  RAIL_GOOD_B_MASK      = 8'h3f;
  localparam logic [7:0]  POWER_FAULT_A_MASK    = 8'hff;
  localparam logic [7:0]  POWER_FAULT_B_MASK    = 8'h1f;
  localparam logic [7:0]  THERMAL_CRIT_MASK     = 8'h1f;
  // rail-good b / power-fault b layout
  localparam int          GATE_DRIVE_LDO_BIT    = 5;
  localparam int          AUX_LDO_1_BIT         = 4;
  localparam int          TERMINATION_LDO_BIT   = 3;
  localparam int          LOAD_SWITCH_B2_BIT    = 2;
  localparam int          LOAD_SWITCH_B1_BIT    = 1;
  localparam int          AUX_LDO_3_BIT         = 0;
  // power-fault a layout
  localparam int          AUX_LDO_2_BIT         = 7;
  localparam int          LOAD_SWITCH_A1_BIT    = 6;
  localparam int          STEP_DOWN_LSB         = 0;
  // thermal layout
  localparam int          REST_OF_DIE_BIT       = 4;
  localparam int          TERMINATION_TEMP_BIT  = 3;
  localparam int          UPPER_RIGHT_BIT       = 2;
  localparam int          UPPER_LEFT_BIT        = 1;
  localparam int          LOWER_RIGHT_BIT       = 0;
endpackage : rail_status_pkg

/* level_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of asynchronous condition levels
module level_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : level_sync

/* sticky_w1c_reg.sv */
`timescale 1ns/1ps
// eight-bit sticky flag register, write one to clear, set beats clear
module sticky_w1c_reg (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // control
  input  wire logic [7:0] valid_mask_i,
  input  wire logic [7:0] set_i,
  input  wire logic       clr_en_i,
  input  wire logic [7:0] clr_data_i,
  // state
  output logic      [7:0] flags_o
);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_o <= rail_status_pkg::FLAG_RESET;
    end else begin
      // a zero written leaves the bit alone; reserved bits never set
      flags_o <= ((flags_o & ~(clr_en_i ? clr_data_i : 8'h00)) | set_i) & valid_mask_i;
    end
  end
endmodule : sticky_w1c_reg

/* rail_fault_thermal_status_bank.sv */
`timescale 1ns/1ps
// status bank: live rail-good b, sticky power-fault a/b and thermal-critical flags

module rail_fault_thermal_status_bank (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_hit_o,
  // rail-in-window conditions, asynchronous
  input  wire logic       gate_drive_ldo_good_i,
  input  wire logic       aux_ldo_1_good_i,
  input  wire logic       termination_ldo_good_i,
  input  wire logic       load_switch_b2_good_i,
  input  wire logic       load_switch_b1_good_i,
  input  wire logic       aux_ldo_3_good_i,
  // loss-of-regulation conditions, asynchronous
  input  wire logic       aux_ldo_2_fault_i,
  input  wire logic       load_switch_a1_fault_i,
  input  wire logic [5:0] step_down_fault_i,
  input  wire logic       aux_ldo_1_fault_i,
  input  wire logic       termination_ldo_fault_i,
  input  wire logic       load_switch_b2_fault_i,
  input  wire logic       load_switch_b1_fault_i,
  input  wire logic       aux_ldo_3_fault_i,
  // over-critical-temperature conditions, asynchronous
  input  wire logic       rest_of_die_overtemp_i,
  input  wire logic       termination_ldo_overtemp_i,
  input  wire logic       upper_right_overtemp_i,
  input  wire logic       upper_left_overtemp_i,
  input  wire logic       lower_right_overtemp_i,
  // flag views
  output logic      [7:0] rail_good_flags_b_o,
  output logic      [7:0] power_fault_flags_a_o,
  output logic      [7:0] power_fault_flags_b_o,
  output logic      [7:0] thermal_critical_flags_o
);
  logic [7:0]  good_raw;
  logic [7:0]  fault_a_raw;
  logic [7:0]  fault_b_raw;
  logic [7:0]  temp_raw;
  logic [31:0] sync_out;
  logic [7:0]  good_s;
  logic [7:0]  fault_a_s;
  logic [7:0]  fault_b_s;
  logic [7:0]  temp_s;
  logic [7:0]  fault_a;
  logic [7:0]  fault_b;
  logic [7:0]  temp_crit;
  logic [7:0]  next_rdata;
  logic        next_hit;
  logic [1:0]  run_age;

  function automatic logic wr_at(input logic we, input logic [7:0] a, input logic [7:0] off);
    wr_at = we && (a == off);
  endfunction : wr_at

  always_comb begin
    good_raw = 8'h00;
    good_raw[rail_status_pkg::GATE_DRIVE_LDO_BIT]  = gate_drive_ldo_good_i;
    good_raw[rail_status_pkg::AUX_LDO_1_BIT]       = aux_ldo_1_good_i;
    good_raw[rail_status_pkg::TERMINATION_LDO_BIT] = termination_ldo_good_i;
    good_raw[rail_status_pkg::LOAD_SWITCH_B2_BIT]  = load_switch_b2_good_i;
    good_raw[rail_status_pkg::LOAD_SWITCH_B1_BIT]  = load_switch_b1_good_i;
    good_raw[rail_status_pkg::AUX_LDO_3_BIT]       = aux_ldo_3_good_i;
    fault_a_raw = 8'h00;
    fault_a_raw[rail_status_pkg::AUX_LDO_2_BIT]      = aux_ldo_2_fault_i;
    fault_a_raw[rail_status_pkg::LOAD_SWITCH_A1_BIT] = load_switch_a1_fault_i;
    fault_a_raw[rail_status_pkg::STEP_DOWN_LSB +: 6] = step_down_fault_i;
    fault_b_raw = 8'h00;
    fault_b_raw[rail_status_pkg::AUX_LDO_1_BIT]       = aux_ldo_1_fault_i;
    fault_b_raw[rail_status_pkg::TERMINATION_LDO_BIT] = termination_ldo_fault_i;
    fault_b_raw[rail_status_pkg::LOAD_SWITCH_B2_BIT]  = load_switch_b2_fault_i;
    fault_b_raw[rail_status_pkg::LOAD_SWITCH_B1_BIT]  = load_switch_b1_fault_i;
    fault_b_raw[rail_status_pkg::AUX_LDO_3_BIT]       = aux_ldo_3_fault_i;
    temp_raw = 8'h00;
    temp_raw[rail_status_pkg::REST_OF_DIE_BIT]      = rest_of_die_overtemp_i;
    temp_raw[rail_status_pkg::TERMINATION_TEMP_BIT] = termination_ldo_overtemp_i;
    temp_raw[rail_status_pkg::UPPER_RIGHT_BIT]      = upper_right_overtemp_i;
    temp_raw[rail_status_pkg::UPPER_LEFT_BIT]       = upper_left_overtemp_i;
    temp_raw[rail_status_pkg::LOWER_RIGHT_BIT]      = lower_right_overtemp_i;
  end

  // analog comparators are asynchronous to clk_i
  level_sync #(.W(32)) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i ({temp_raw, fault_b_raw, fault_a_raw, good_raw}),
    .sync_o  (sync_out)
  );

  assign good_s    = sync_out[7:0] & rail_status_pkg::RAIL_GOOD_B_MASK;
  assign fault_a_s = sync_out[15:8];
  assign fault_b_s = sync_out[23:16];
  assign temp_s    = sync_out[31:24];

  sticky_w1c_reg u_fault_a (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .valid_mask_i (rail_status_pkg::POWER_FAULT_A_MASK),
    .set_i        (fault_a_s),
    .clr_en_i     (wr_at(reg_wr_i, reg_addr_i, rail_status_pkg::POWER_FAULT_A_OFFSET)),
    .clr_data_i   (reg_wdata_i),
    .flags_o      (fault_a)
  );

  sticky_w1c_reg u_fault_b (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .valid_mask_i (rail_status_pkg::POWER_FAULT_B_MASK),
    .set_i        (fault_b_s),
    .clr_en_i     (wr_at(reg_wr_i, reg_addr_i, rail_status_pkg::POWER_FAULT_B_OFFSET)),
    .clr_data_i   (reg_wdata_i),
    .flags_o      (fault_b)
  );

  sticky_w1c_reg u_temp (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .valid_mask_i (rail_status_pkg::THERMAL_CRIT_MASK),
    .set_i        (temp_s),
    .clr_en_i     (wr_at(reg_wr_i, reg_addr_i, rail_status_pkg::THERMAL_CRIT_OFFSET)),
    .clr_data_i   (reg_wdata_i),
    .flags_o      (temp_crit)
  );

  // rail-good b has no write path at all
  always_comb begin
    next_hit = 1'b1;
    unique case (reg_addr_i)
      rail_status_pkg::RAIL_GOOD_B_OFFSET:   next_rdata = good_s;
      rail_status_pkg::POWER_FAULT_A_OFFSET: next_rdata = fault_a;
      rail_status_pkg::POWER_FAULT_B_OFFSET: next_rdata = fault_b;
      rail_status_pkg::THERMAL_CRIT_OFFSET:  next_rdata = temp_crit;
      default: begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
      end
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
      reg_hit_o   <= 1'b0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
      reg_hit_o   <= next_hit;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rail_good_flags_b_o      <= rail_status_pkg::FLAG_RESET;
      power_fault_flags_a_o    <= rail_status_pkg::FLAG_RESET;
      power_fault_flags_b_o    <= rail_status_pkg::FLAG_RESET;
      thermal_critical_flags_o <= rail_status_pkg::FLAG_RESET;
    end else begin
      rail_good_flags_b_o      <= good_s;
      power_fault_flags_a_o    <= fault_a;
      power_fault_flags_b_o    <= fault_b;
      thermal_critical_flags_o <= temp_crit;
    end
  end

  // running edges since reset release, saturating; keeps pipeline checks clear of reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_age <= 2'b00;
    end else if (run_age != 2'b11) begin
      run_age <= run_age + 2'b01;
    end
  end

  AST_GOOD_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    1'b1 |=> rail_good_flags_b_o == $past(good_s))
    else $error("rail-good view does not follow synchronised level");
  AST_GOOD_RESERVED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rail_good_flags_b_o[7:6] == 2'b00)
    else $error("rail-good reserved bits set");
  AST_GOOD_NO_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reg_wr_i && reg_addr_i == rail_status_pkg::RAIL_GOOD_B_OFFSET ##1 $stable(sync_out[7:0]) |-> $stable(good_s))
    else $error("write disturbed rail-good");
  AST_FAULT_A_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    fault_a_s[rail_status_pkg::AUX_LDO_2_BIT] |=> fault_a[rail_status_pkg::AUX_LDO_2_BIT])
    else $error("aux ldo 2 fault not latched");
  AST_FAULT_B_RSV: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    fault_b[7:5] == 3'b000)
    else $error("fault b reserved bits set");
  AST_FAULT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_at(reg_wr_i, reg_addr_i, rail_status_pkg::POWER_FAULT_A_OFFSET) && reg_wdata_i[0] && !fault_a_s[0]
    |=> !fault_a[0])
    else $error("fault a bit 0 not cleared by write one");
  AST_TEMP_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    temp_raw[rail_status_pkg::REST_OF_DIE_BIT] ##1 temp_raw[rail_status_pkg::REST_OF_DIE_BIT]
    ##1 temp_raw[rail_status_pkg::REST_OF_DIE_BIT] |=> temp_crit[rail_status_pkg::REST_OF_DIE_BIT])
    else $error("die overtemp not latched");
  AST_TEMP_RSV: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    thermal_critical_flags_o[7:5] == 3'b000)
    else $error("thermal reserved bits set");
  AST_STICKY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    temp_crit[1] && !(reg_wr_i && reg_addr_i == rail_status_pkg::THERMAL_CRIT_OFFSET && reg_wdata_i[1])
    |=> temp_crit[1])
    else $error("thermal flag dropped without clear");
  AST_READ_FAULT_B: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == rail_status_pkg::POWER_FAULT_B_OFFSET |=> reg_rdata_o == $past(fault_b) && reg_hit_o)
    else $error("fault b read mismatch");

  // reset values; no disable here so the reset itself is watched
  AST_RESET_FLAGS: assert property (@(posedge clk_i)
    !rst_b_i && $past(!rst_b_i) |-> fault_a == 8'h00 && fault_b == 8'h00 && temp_crit == 8'h00)
    else $error("flags not cleared by reset");
  AST_RESET_OUTPUTS: assert property (@(posedge clk_i)
    !rst_b_i && $past(!rst_b_i) |-> reg_rdata_o == 8'h00 && !reg_hit_o && rail_good_flags_b_o == 8'h00
      && power_fault_flags_a_o == 8'h00 && power_fault_flags_b_o == 8'h00 && thermal_critical_flags_o == 8'h00)
    else $error("outputs not cleared by reset");

  // a level seen at edge n shows at edge n+3: two sync stages, then the flag
  AST_GOOD_MAP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    run_age == 2'b11 |-> rail_good_flags_b_o == $past(good_raw, 3))
    else $error("rail-good view does not match its inputs");
  AST_FAULT_A_MAP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    run_age == 2'b11 |-> (fault_a & $past(fault_a_raw, 3)) == $past(fault_a_raw, 3))
    else $error("fault a flag missing for its condition");
  AST_FAULT_B_MAP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    run_age == 2'b11 |-> (fault_b & $past(fault_b_raw, 3)) == $past(fault_b_raw, 3))
    else $error("fault b flag missing for its condition");
  AST_TEMP_MAP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    run_age == 2'b11 |-> (temp_crit & $past(temp_raw, 3)) == $past(temp_raw, 3))
    else $error("thermal flag missing for its sensor");

  // write one clears unless the condition is still present; write zero leaves the bit
  AST_FAULT_B_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_at(reg_wr_i, reg_addr_i, rail_status_pkg::POWER_FAULT_B_OFFSET)
    |=> (fault_b & $past(reg_wdata_i & ~fault_b_s)) == 8'h00)
    else $error("fault b bit not cleared by write one");
  AST_TEMP_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_at(reg_wr_i, reg_addr_i, rail_status_pkg::THERMAL_CRIT_OFFSET)
    |=> (temp_crit & $past(reg_wdata_i & ~temp_s)) == 8'h00)
    else $error("thermal bit not cleared by write one");
  AST_FAULT_A_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_at(reg_wr_i, reg_addr_i, rail_status_pkg::POWER_FAULT_A_OFFSET)
    |=> ($past(fault_a & ~reg_wdata_i) & ~fault_a) == 8'h00)
    else $error("fault a bit lost on write zero");
  AST_TEMP_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_at(reg_wr_i, reg_addr_i, rail_status_pkg::THERMAL_CRIT_OFFSET)
    |=> ($past(temp_crit & ~reg_wdata_i) & ~temp_crit) == 8'h00)
    else $error("thermal bit lost on write zero");
  AST_FAULT_B_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !wr_at(reg_wr_i, reg_addr_i, rail_status_pkg::POWER_FAULT_B_OFFSET) |=> ($past(fault_b) & ~fault_b) == 8'h00)
    else $error("fault b bit dropped without clear");

  // flags rise only from their own synchronised condition
  AST_FAULT_A_ONLY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    1'b1 |-> (fault_a & ~$past(fault_a) & ~$past(fault_a_s)) == 8'h00)
    else $error("fault a bit set without condition");
  AST_FAULT_B_ONLY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    1'b1 |-> (fault_b & ~$past(fault_b) & ~$past(fault_b_s)) == 8'h00)
    else $error("fault b bit set without condition");
  AST_TEMP_ONLY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    1'b1 |-> (temp_crit & ~$past(temp_crit) & ~$past(temp_s)) == 8'h00)
    else $error("thermal bit set without sensor");

  // read port returns the addressed register one edge after the strobe
  AST_READ_GOOD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == rail_status_pkg::RAIL_GOOD_B_OFFSET |=> reg_rdata_o == $past(good_s) && reg_hit_o)
    else $error("rail-good read mismatch");
  AST_READ_FAULT_A: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == rail_status_pkg::POWER_FAULT_A_OFFSET |=> reg_rdata_o == $past(fault_a) && reg_hit_o)
    else $error("fault a read mismatch");
  AST_READ_TEMP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == rail_status_pkg::THERMAL_CRIT_OFFSET |=> reg_rdata_o == $past(temp_crit) && reg_hit_o)
    else $error("thermal read mismatch");
  AST_READ_MISS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reg_rd_i && (reg_addr_i < rail_status_pkg::RAIL_GOOD_B_OFFSET || reg_addr_i > rail_status_pkg::THERMAL_CRIT_OFFSET)
    |=> reg_rdata_o == 8'h00 && !reg_hit_o)
    else $error("unmapped read not refused");

  // host-visible views trail the internal flags by one edge
  AST_VIEW_FAULT_A: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    1'b1 |=> power_fault_flags_a_o == $past(fault_a))
    else $error("fault a view mismatch");
  AST_VIEW_FAULT_B: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    1'b1 |=> power_fault_flags_b_o == $past(fault_b))
    else $error("fault b view mismatch");
  AST_VIEW_TEMP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    1'b1 |=> thermal_critical_flags_o == $past(temp_crit))
    else $error("thermal view mismatch");

  COV_FAULT_SET: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(fault_b[2]));
  COV_TEMP_CLEAR: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(temp_crit[4]));
  COV_MISS: cover property (@(posedge clk_i) disable iff (!rst_b_i) reg_rd_i ##1 !reg_hit_o);
  COV_SET_WINS: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_at(reg_wr_i, reg_addr_i, rail_status_pkg::POWER_FAULT_A_OFFSET) && reg_wdata_i[0] && fault_a_s[0]);
  COV_GOOD_WRITE: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    reg_wr_i && reg_addr_i == rail_status_pkg::RAIL_GOOD_B_OFFSET);
endmodule : rail_fault_thermal_status_bank

/* host_model.sv */
`timescale 1ns/1ps
// host model: strobe-port register master standing in for the controller
module host_model (
  // clock
  input  wire logic       clk_i,
  // register port
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_hit_i
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end

  // a one in the data clears that flag, a zero leaves it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr

  // released lines show the inverse so stale values never look valid
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
    h = reg_hit_i;
  endtask : rd
endmodule : host_model

/* tb_rail_fault_thermal_status_bank.sv */
`timescale 1ns/1ps
// self-checking bench for the rail status bank
module tb_rail_fault_thermal_status_bank;
  logic       clk;
  logic       rst_b;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;
  logic       hit;
  logic [5:0] good;
  logic [7:0] fa;
  logic [4:0] fb;
  logic [4:0] tc;
  logic [7:0] vw [4];
  int         n_mismatch;
  int         samples_checked;
  int         cycles;

  rail_fault_thermal_status_bank dut_u (
    .clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_hit_o(hit),
    .gate_drive_ldo_good_i(good[5]), .aux_ldo_1_good_i(good[4]), .termination_ldo_good_i(good[3]),
    .load_switch_b2_good_i(good[2]), .load_switch_b1_good_i(good[1]), .aux_ldo_3_good_i(good[0]),
    .aux_ldo_2_fault_i(fa[7]), .load_switch_a1_fault_i(fa[6]), .step_down_fault_i(fa[5:0]),
    .aux_ldo_1_fault_i(fb[4]), .termination_ldo_fault_i(fb[3]), .load_switch_b2_fault_i(fb[2]),
    .load_switch_b1_fault_i(fb[1]), .aux_ldo_3_fault_i(fb[0]),
    .rest_of_die_overtemp_i(tc[4]), .termination_ldo_overtemp_i(tc[3]), .upper_right_overtemp_i(tc[2]),
    .upper_left_overtemp_i(tc[1]), .lower_right_overtemp_i(tc[0]),
    .rail_good_flags_b_o(vw[0]), .power_fault_flags_a_o(vw[1]), .power_fault_flags_b_o(vw[2]),
    .thermal_critical_flags_o(vw[3])
  );

  host_model host_u (
    .clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd),
    .reg_rdata_i(rdata), .reg_hit_i(hit)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // ceiling well above the roughly 520 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("Error at %0t: timeout", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    logic [7:0] d;
    logic       h;
    host_u.rd(a, d, h);
    chk(d, exp, "read data");
    chk({7'h00, h}, {7'h00, exp_hit}, "hit");
  endtask : rd_chk

  // two sync edges plus flag and view registers, with margin
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle

  task automatic drive(input int sel, input logic [7:0] v);
    @(posedge clk);
    case (sel)
      0: good <= v[5:0];
      1: fa   <= v;
      2: fb   <= v[4:0];
      default: tc <= v[4:0];
    endcase
    settle();
  endtask : drive

  task automatic t_reset;
    rd_chk(8'hb1, 8'h00, 1'b1);
    rd_chk(8'hb2, 8'h00, 1'b1);
    rd_chk(8'hb3, 8'h00, 1'b1);
    rd_chk(8'hb4, 8'h00, 1'b1);
    rd_chk(8'hb5, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      chk(vw[i], 8'h00, "reset view");
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_rail_good;
    for (int i = 0; i < 6; i++) begin
      drive(0, 8'h01 << i);
      rd_chk(8'hb1, 8'h01 << i, 1'b1);
    end
    drive(0, 8'h2a);
    host_u.wr(8'hb1, 8'hff);
    rd_chk(8'hb1, 8'h2a, 1'b1);
    chk(vw[0], 8'h2a, "good view");
    drive(0, 8'h00);
    rd_chk(8'hb1, 8'h00, 1'b1);
    $display("test rail good done");
  endtask : t_rail_good

  // sel 1..3 picks fault a, fault b or thermal; flags set one at a time
  task automatic t_sticky(input int sel, input logic [7:0] mask);
    logic [7:0] a;
    logic [7:0] acc;
    a   = 8'hb1 + 8'(sel);
    acc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (mask[i]) begin
        drive(sel, 8'h01 << i);
        drive(sel, 8'h00);
        acc = acc | (8'h01 << i);
        rd_chk(a, acc, 1'b1);
      end
    end
    chk(vw[sel], mask, "flag view");
    host_u.wr(a, 8'h00);
    rd_chk(a, mask, 1'b1);
    host_u.wr(a, 8'h01);
    rd_chk(a, mask & 8'hfe, 1'b1);
    host_u.wr(a, 8'hff);
    rd_chk(a, 8'h00, 1'b1);
    drive(sel, 8'h01);
    host_u.wr(a, 8'h01);
    rd_chk(a, 8'h01, 1'b1);
    drive(sel, 8'h00);
    host_u.wr(a, 8'h01);
    rd_chk(a, 8'h00, 1'b1);
    $display("test sticky register %h done", a);
  endtask : t_sticky

  // flags set, conditions gone, then a reset pulse mid-run must clear them
  task automatic t_mid_reset;
    drive(1, 8'h81);
    drive(3, 8'h10);
    drive(1, 8'h00);
    drive(3, 8'h00);
    rd_chk(8'hb2, 8'h81, 1'b1);
    rd_chk(8'hb4, 8'h10, 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(8'hb2, 8'h00, 1'b1);
    rd_chk(8'hb4, 8'h00, 1'b1);
    chk(vw[1], 8'h00, "view after reset");
    $display("test mid-run reset done");
  endtask : t_mid_reset

  initial begin
    n_mismatch      = 0;
    samples_checked = 0;
    cycles          = 0;
    rst_b           = 1'b0;
    good            = 6'h00;
    fa              = 8'h00;
    fb              = 5'h00;
    tc              = 5'h00;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_rail_good();
    t_sticky(1, 8'hff);
    t_sticky(2, 8'h1f);
    t_sticky(3, 8'h1f);
    t_mid_reset();
    end_sim();
  end
endmodule : tb_rail_fault_thermal_status_bank
